// ===== cusf_pkg.sv
`default_nettype none
package cusf_pkg;
    localparam logic [4:0]  SCRATCH_NUM     = 5'h04;
    localparam logic [2:0]  SCRATCH_SEL     = 3'h2;
    localparam logic [4:0]  HWREN_NUM       = 5'h07;
    localparam logic [2:0]  HWREN_SEL       = 3'h0;
    localparam logic [4:0]  FAULT_NUM       = 5'h08;
    localparam logic [2:0]  FAULT_SEL       = 3'h0;
    localparam logic [4:0]  HWR_SCRATCH_NUM = 5'h1D;
    localparam int          HWREN_USER_BIT  = 29;
    localparam int          HWREN_MASK_LSB  = 0;
    localparam int          HWREN_MASK_W    = 4;
    localparam logic [31:0] HWREN_WR_MASK   = 32'h2000000F;
    localparam logic [31:0] SCRATCH_RESET   = 32'h00000000;
    localparam logic [31:0] HWREN_RESET     = 32'h00000000;
    localparam logic [31:0] FAULT_RESET     = 32'h00000000;
    localparam logic [31:0] PRIV_REGION     = 32'h80000000;
    typedef enum logic [1:0] {
        CUSF_SIZE_BYTE = 2'b00,
        CUSF_SIZE_HALF = 2'b01,
        CUSF_SIZE_WORD = 2'b10
    } cusf_size_t;
endpackage
`default_nettype wire

// ===== cusf_acc_if.sv
`default_nettype none
interface cusf_acc_if;
    logic                   valid;
    logic [31:0]            addr;
    cusf_pkg::cusf_size_t   size;
    logic                   unpriv;
    logic                   err;
    modport core  (output valid, output addr, output size, output unpriv, input err);
    modport check (input valid, input addr, input size, input unpriv, output err);
endinterface
`default_nettype wire

// ===== cusf_addr_check.sv
`default_nettype none
module cusf_addr_check (
    cusf_acc_if.check acc
);
    logic misaligned;
    logic priv_hit;

    // an illegal size code is treated as misaligned rather than silently passed
    assign misaligned = (acc.size == cusf_pkg::CUSF_SIZE_HALF) ? acc.addr[0] :
                        (acc.size == cusf_pkg::CUSF_SIZE_WORD) ? (acc.addr[1:0] != 2'b00) :
                        (acc.size == cusf_pkg::CUSF_SIZE_BYTE) ? 1'b0 : 1'b1;
    assign priv_hit   = acc.unpriv && (acc.addr >= cusf_pkg::PRIV_REGION);
    assign acc.err    = acc.valid && (misaligned || priv_hit);
endmodule
`default_nettype wire

// ===== cusf_regs.sv
// Functional notes
// - 32-bit scratch word, stores value, no effect
// - unprivileged read-hardware number 29 returns scratch when configured
// - enable bit 29 gates unprivileged scratch access
// - bits 31-30, 28-4 read zero, ignore writes
// - mask bits 3-0 read-write, reset zero, gate access
// - scratch enable bit exists only when configured
// - faulting address loaded on each address error
// - misaligned load, store, fetch raises address error
// - unprivileged access to privileged region errors
// - bus errors leave faulting address unchanged
// - unprivileged means user bit set, both levels clear
`default_nettype none
module cusf_regs #(
    parameter bit HAS_SCRATCH_ENABLE = 1'b1
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   cp_wr,
    input  wire logic                   cp_rd,
    input  wire logic [4:0]             cp_num,
    input  wire logic [2:0]             cp_sel,
    input  wire logic [31:0]            cp_wdata,
    output var  logic [31:0]            cp_rdata,
    output var  logic                   cp_rvalid,
    input  wire logic                   user_mode_bit,
    input  wire logic                   exception_level_bit,
    input  wire logic                   error_level_bit,
    input  wire logic                   hwr_req,
    input  wire logic [4:0]             hwr_num,
    input  wire logic [127:0]           hwr_src,
    output var  logic [31:0]            hwr_rdata,
    output var  logic                   hwr_done,
    output var  logic                   hwr_ri_exc,
    input  wire logic                   acc_valid,
    input  wire logic [31:0]            acc_addr,
    input  wire cusf_pkg::cusf_size_t   acc_size,
    input  wire logic                   bus_err,
    output var  logic                   addr_err_exc,
    output var  logic [31:0]            fault_vaddr
);
    logic [31:0] user_scratch_word;
    logic [31:0] hw_read_enable;
    logic [31:0] faulting_address;
    logic        unpriv;
    logic        sel_scratch;
    logic        sel_hwren;
    logic        sel_fault;
    logic [31:0] wr_mask;
    logic [31:0] next_hwren;
    logic [31:0] next_rdata;
    logic        hwr_is_mask;
    logic        hwr_is_scratch;
    logic        hwr_known;
    logic        hwr_enabled;
    logic        hwr_allowed;
    logic [31:0] next_hwr_data;
    logic        addr_err;

    function automatic logic cp_hit(input logic [4:0] num, input logic [2:0] sel,
                                    input logic [4:0] rnum, input logic [2:0] rsel);
        return (num == rnum) && (sel == rsel);
    endfunction

    cusf_acc_if acc ();

    assign unpriv      = user_mode_bit && !exception_level_bit && !error_level_bit;
    assign sel_scratch = cp_hit(cp_num, cp_sel, cusf_pkg::SCRATCH_NUM, cusf_pkg::SCRATCH_SEL);
    assign sel_hwren   = cp_hit(cp_num, cp_sel, cusf_pkg::HWREN_NUM, cusf_pkg::HWREN_SEL);
    assign sel_fault   = cp_hit(cp_num, cp_sel, cusf_pkg::FAULT_NUM, cusf_pkg::FAULT_SEL);

    // without the optional enable the bit is simply not stored, so it reads zero
    assign wr_mask    = HAS_SCRATCH_ENABLE ? cusf_pkg::HWREN_WR_MASK
                        : (cusf_pkg::HWREN_WR_MASK & ~(32'h1 << cusf_pkg::HWREN_USER_BIT));
    assign next_hwren = cp_wdata & wr_mask;

    // unmapped numbers read zero; the faulting address is also driven out on fault_vaddr
    assign next_rdata = sel_scratch ? user_scratch_word :
                        sel_hwren   ? hw_read_enable :
                        sel_fault   ? faulting_address : 32'h00000000;

    assign hwr_is_mask    = (hwr_num < 5'(cusf_pkg::HWREN_MASK_W));
    assign hwr_is_scratch = HAS_SCRATCH_ENABLE && (hwr_num == cusf_pkg::HWR_SCRATCH_NUM);
    assign hwr_known      = hwr_is_mask || hwr_is_scratch;
    assign hwr_enabled    = hwr_is_scratch ? hw_read_enable[cusf_pkg::HWREN_USER_BIT]
                            : hw_read_enable[hwr_num[1:0]];
    assign hwr_allowed    = hwr_known && (!unpriv || hwr_enabled);
    assign next_hwr_data  = hwr_is_scratch ? user_scratch_word
                            : hwr_src[{hwr_num[1:0], 5'h00} +: 32];

    assign acc.valid  = acc_valid;
    assign acc.addr   = acc_addr;
    assign acc.size   = acc_size;
    assign acc.unpriv = unpriv;
    assign addr_err   = acc.err;

    cusf_addr_check u_check (
        .acc (acc.check)
    );

    // the scratch word is pure storage; nothing in the block looks at its value
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            user_scratch_word <= cusf_pkg::SCRATCH_RESET;
        end else if (cp_wr && sel_scratch) begin
            user_scratch_word <= cp_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hw_read_enable <= cusf_pkg::HWREN_RESET;
        end else if (cp_wr && sel_hwren) begin
            hw_read_enable <= next_hwren;
        end
    end

    // bus_err is deliberately absent: only address errors move this register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            faulting_address <= cusf_pkg::FAULT_RESET;
        end else if (addr_err) begin
            faulting_address <= acc_addr;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cp_rdata  <= 32'h00000000;
            cp_rvalid <= 1'b0;
        end else begin
            cp_rdata  <= cp_rd ? next_rdata : 32'h00000000;
            cp_rvalid <= cp_rd;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hwr_rdata  <= 32'h00000000;
            hwr_done   <= 1'b0;
            hwr_ri_exc <= 1'b0;
        end else begin
            hwr_rdata  <= (hwr_req && hwr_allowed) ? next_hwr_data : 32'h00000000;
            hwr_done   <= hwr_req;
            hwr_ri_exc <= hwr_req && !hwr_allowed;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_err_exc <= 1'b0;
            fault_vaddr  <= cusf_pkg::FAULT_RESET;
        end else begin
            addr_err_exc <= addr_err;
            fault_vaddr  <= addr_err ? acc_addr : faulting_address;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_scratch_hold;
        !(cp_wr && sel_scratch) |=> (user_scratch_word == $past(user_scratch_word));
    endproperty
    a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed unwritten");

    property p_hwr_scratch;
        hwr_req && hwr_is_scratch && hwr_allowed |=> hwr_done && !hwr_ri_exc
            && (hwr_rdata == $past(user_scratch_word));
    endproperty
    a_hwr_scratch: assert property (p_hwr_scratch) else $error("scratch read wrong");

    property p_scratch_block;
        hwr_req && hwr_is_scratch && unpriv && !hw_read_enable[cusf_pkg::HWREN_USER_BIT]
            |=> hwr_ri_exc && (hwr_rdata == 32'h00000000);
    endproperty
    a_scratch_block: assert property (p_scratch_block) else $error("scratch access not blocked");

    property p_unimpl_zero;
        (hw_read_enable & ~cusf_pkg::HWREN_WR_MASK) == 32'h00000000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_mask_gate;
        hwr_req && hwr_is_mask && unpriv |=>
            hwr_ri_exc == !$past(hw_read_enable[hwr_num[1:0]]);
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("mask gating wrong");

    property p_opt_bit;
        !HAS_SCRATCH_ENABLE |-> !hw_read_enable[cusf_pkg::HWREN_USER_BIT];
    endproperty
    a_opt_bit: assert property (p_opt_bit) else $error("absent enable bit set");

    property p_fault_load;
        addr_err |=> addr_err_exc && (faulting_address == $past(acc_addr))
            && (fault_vaddr == faulting_address);
    endproperty
    a_fault_load: assert property (p_fault_load) else $error("fault address not loaded");

    property p_misalign;
        acc_valid && (acc_size == cusf_pkg::CUSF_SIZE_WORD) && (acc_addr[1:0] != 2'b00)
            |=> addr_err_exc;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned word missed");

    property p_priv_region;
        acc_valid && unpriv && acc_addr[31] |=> addr_err_exc;
    endproperty
    a_priv_region: assert property (p_priv_region) else $error("privileged access missed");

    property p_bus_err;
        bus_err && !addr_err |=> $stable(faulting_address);
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error moved fault address");

    property p_priv_always;
        hwr_req && hwr_known && (!user_mode_bit || exception_level_bit || error_level_bit)
            |=> !hwr_ri_exc;
    endproperty
    a_priv_always: assert property (p_priv_always) else $error("privileged read refused");

    property p_unknown_ri;
        hwr_req && !hwr_known |=> hwr_done && hwr_ri_exc && (hwr_rdata == 32'h00000000);
    endproperty
    a_unknown_ri: assert property (p_unknown_ri) else $error("unknown number accepted");

    c_scratch_read: cover property (hwr_req && hwr_is_scratch && unpriv && hwr_allowed);
    c_ri_exc:       cover property (hwr_req && unpriv && !hwr_allowed);
    c_misalign:     cover property (addr_err && !acc.unpriv);
    c_bus_only:     cover property (bus_err && !addr_err);
endmodule
`default_nettype wire

// ===== cusf_core_model.sv
`default_nettype none
module cusf_core_model (
    input  wire logic                 mclk,
    output var  logic                 cp_wr,
    output var  logic                 cp_rd,
    output var  logic [4:0]           cp_num,
    output var  logic [2:0]           cp_sel,
    output var  logic [31:0]          cp_wdata,
    input  wire logic [31:0]          cp_rdata,
    input  wire logic                 cp_rvalid,
    output var  logic                 user_mode_bit,
    output var  logic                 exception_level_bit,
    output var  logic                 error_level_bit,
    output var  logic                 hwr_req,
    output var  logic [4:0]           hwr_num,
    output var  logic [127:0]         hwr_src,
    input  wire logic [31:0]          hwr_rdata,
    input  wire logic                 hwr_done,
    input  wire logic                 hwr_ri_exc,
    output var  logic                 acc_valid,
    output var  logic [31:0]          acc_addr,
    output var  cusf_pkg::cusf_size_t acc_size,
    output var  logic                 bus_err,
    input  wire logic                 addr_err_exc,
    input  wire logic [31:0]          fault_vaddr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cp_wr, cp_rd, hwr_req, acc_valid, bus_err} = '0;
        {user_mode_bit, exception_level_bit, error_level_bit} = '0;
        {cp_num, cp_sel, cp_wdata, hwr_num, acc_addr} = '0;
        acc_size = cusf_pkg::CUSF_SIZE_WORD;
        // distinct words so a wrong hardware register index shows up
        hwr_src = {32'h33330003, 32'h22220002, 32'h11110001, 32'h0A0A0000};
    end
    // answers stand one cycle, so each task samples them just after the taking edge
    task automatic cp_op(input logic w, input logic [4:0] n, input logic [2:0] s,
                         input logic [31:0] d, output logic [32:0] r);
        @(posedge mclk);
        {cp_wr, cp_rd, cp_num, cp_sel, cp_wdata} <= {w, !w, n, s, d};
        @(posedge mclk);
        {cp_wr, cp_rd, cp_wdata} <= {2'b00, ~d};
        #1;
        r = {cp_rvalid, cp_rdata};
    endtask
    task automatic hwr(input logic [2:0] m, input logic [4:0] n, output logic [33:0] r);
        @(posedge mclk);
        {user_mode_bit, exception_level_bit, error_level_bit, hwr_req, hwr_num} <= {m, 1'b1, n};
        @(posedge mclk);
        {hwr_req, hwr_num} <= {1'b0, ~n};
        #1;
        r = {hwr_done, hwr_ri_exc, hwr_rdata};
    endtask
    task automatic acc(input logic um, input logic [31:0] a, input cusf_pkg::cusf_size_t z,
                       input logic be, output logic [32:0] r);
        @(posedge mclk);
        {user_mode_bit, exception_level_bit, error_level_bit} <= {um, 2'b00};
        {acc_valid, acc_addr, bus_err} <= {1'b1, a, be};
        acc_size <= z;
        @(posedge mclk);
        {acc_valid, acc_addr, bus_err} <= {1'b0, ~a, 1'b0};
        #1;
        r = {addr_err_exc, fault_vaddr};
    endtask
endmodule
`default_nettype wire

// ===== cusf_regs_bench.sv
`default_nettype none
module cusf_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst_n, cp_wr, cp_rd, cp_rvalid, hwr_req, hwr_done, hwr_ri_exc;
    logic user_mode_bit, exception_level_bit, error_level_bit, acc_valid, bus_err, addr_err_exc;
    logic [4:0]   cp_num, hwr_num;
    logic [2:0]   cp_sel;
    logic [31:0]  cp_wdata, cp_rdata, hwr_rdata, acc_addr, fault_vaddr;
    logic [127:0] hwr_src;
    cusf_pkg::cusf_size_t acc_size;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    always #50 mclk = ~mclk;
    cusf_regs i_cusf_regs (.*);
    cusf_core_model i_cusf_core_model (.*);
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("mismatches %0d of %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cp(input logic w, input logic [4:0] n, input logic [2:0] s,
                      input logic [31:0] d, output logic [32:0] r);
        i_cusf_core_model.cp_op(w, n, s, d, r);
    endtask
    task automatic t_regs;
        logic [32:0] r;
        cp(1'b0, cusf_pkg::HWREN_NUM, cusf_pkg::HWREN_SEL, 32'h0, r);
        chk(r, 33'h100000000);
        cp(1'b1, cusf_pkg::SCRATCH_NUM, cusf_pkg::SCRATCH_SEL, 32'hA5C35A3C, r);
        cp(1'b0, cusf_pkg::SCRATCH_NUM, cusf_pkg::SCRATCH_SEL, 32'h0, r);
        chk(r, 33'h1A5C35A3C);
        cp(1'b1, cusf_pkg::HWREN_NUM, cusf_pkg::HWREN_SEL, 32'hFFFFFFFF, r);
        cp(1'b0, cusf_pkg::HWREN_NUM, cusf_pkg::HWREN_SEL, 32'h0, r);
        chk(r, 33'h12000000F);
        cp(1'b1, cusf_pkg::FAULT_NUM, cusf_pkg::FAULT_SEL, 32'hFFFFFFFF, r);
        cp(1'b0, cusf_pkg::FAULT_NUM, cusf_pkg::FAULT_SEL, 32'h0, r);
        chk(r, 33'h100000000);
    endtask
    task automatic t_hwr;
        logic [33:0] h;
        logic [32:0] r;
        i_cusf_core_model.hwr(3'b100, 5'h1D, h);
        chk(h, 34'h2A5C35A3C);
        cp(1'b1, cusf_pkg::HWREN_NUM, cusf_pkg::HWREN_SEL, 32'h0000000A, r);
        i_cusf_core_model.hwr(3'b100, 5'h1D, h);
        chk(h, 34'h300000000);
        i_cusf_core_model.hwr(3'b101, 5'h1D, h);
        chk(h, 34'h2A5C35A3C);
        i_cusf_core_model.hwr(3'b110, 5'h1D, h);
        chk(h, 34'h2A5C35A3C);
        for (int i = 0; i < 4; i++) begin
            i_cusf_core_model.hwr(3'b100, 5'(i), h);
            chk(h, (i % 2) ? {2'b10, hwr_src[32*i +: 32]} : 34'h300000000);
        end
        i_cusf_core_model.hwr(3'b000, 5'h00, h);
        chk(h, {2'b10, hwr_src[31:0]});
        // numbers outside the mask range and the scratch slot are refused even when privileged
        i_cusf_core_model.hwr(3'b000, 5'h05, h);
        chk(h, 34'h300000000);
    endtask
    task automatic t_acc;
        logic [32:0] r;
        i_cusf_core_model.acc(1'b0, 32'h00000002, cusf_pkg::CUSF_SIZE_WORD, 1'b0, r);
        chk(r, 33'h100000002);
        i_cusf_core_model.acc(1'b0, 32'h00000101, cusf_pkg::CUSF_SIZE_HALF, 1'b0, r);
        chk(r, 33'h100000101);
        i_cusf_core_model.acc(1'b0, 32'h00000013, cusf_pkg::CUSF_SIZE_BYTE, 1'b0, r);
        chk(r, 33'h000000101);
        i_cusf_core_model.acc(1'b1, 32'h80000000, cusf_pkg::CUSF_SIZE_WORD, 1'b0, r);
        chk(r, 33'h180000000);
        i_cusf_core_model.acc(1'b0, 32'h80000004, cusf_pkg::CUSF_SIZE_WORD, 1'b0, r);
        chk(r, 33'h080000000);
        i_cusf_core_model.acc(1'b0, 32'h00000008, cusf_pkg::CUSF_SIZE_WORD, 1'b1, r);
        chk(r, 33'h080000000);
        cp(1'b0, cusf_pkg::FAULT_NUM, cusf_pkg::FAULT_SEL, 32'h0, r);
        chk(r, 33'h180000000);
        i_cusf_core_model.acc(1'b0, 32'h00000010, cusf_pkg::cusf_size_t'(2'b11), 1'b0, r);
        chk(r, 33'h100000010);
    endtask
    // ceiling well above the under sixty cycles the sequence needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_hwr();
        t_acc();
        results();
    end
endmodule
`default_nettype wire
